/* rtl/cstc_top.sv */
// channel sync and tuning control: event hold-offs, shadowed frequency
// word, input selection, sample-rate modes and comb filter settings.
// assumes avalon-mm master on clk_sys, adc pins synchronous to clk_sys.
//
// Behaviour
// [R1] pin event enables start and hop hold-offs
// [R2] start hold-off reaching one leaves sleep
// [R3] start while running realigns filter phase
// [R4] start hold-off one immediate, zero none
// [R5] hop hold-off reaching one loads frequency
// [R6] hop hold-off one immediate, zero none
// [R7] bit 3 clears phase accumulator on hop
// [R8] shadow halves copied on wake or hop
// [R9] hold-off one copies shadow on write
// [R10] 16-bit phase offset to oscillator
// [R11] two bits select one of four align pins
// [R12] bit 6 selects input port b
// [R13] mode 00 every edge, zero when unqualified
// [R14] mode 01 samples where qualifier high
// [R15] mode 10 sample after qualifier rise
// [R16] mode 11 sample after qualifier fall
// [R17] two bits enable oscillator dither sources
// [R18] bit 0 bypasses translation, a to i, b to q
// [R19] decimation minus one, 1 to 4096
// [R20] interpolation minus one, 1 to 512
// [R21] scale bit 11 polarity, bit 10 weight
// [R22] level pin selects high or low scale
// [R23] soft event bits launch hold-off countdowns
// [R24] start and hop counters run independently
// [R25] counters decrement once per accepted sample
//
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ps
module cstc_top
  import cstc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [cstc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire cstc_pkg::cstc_port_type port_a,
  input wire cstc_pkg::cstc_port_type port_b,
  input wire logic [3:0] align_pins,
  input wire logic level_indicator_pin,
  output logic channel_asleep,
  output logic channel_sample_valid,
  output cstc_pkg::cstc_sample_type channel_sample,
  output cstc_pkg::cstc_sample_type quadrature_sample,
  output logic filter_realign,
  output logic [31:0] tuning_oscillator_freq,
  output logic [15:0] tuning_oscillator_phase_offset,
  output logic tuning_oscillator_acc_clear,
  output logic [1:0] tuning_oscillator_dither,
  output logic tuning_oscillator_bypass,
  output logic [11:0] comb_decimation_factor,
  output logic [8:0] comb_interpolation_factor,
  output cstc_pkg::cstc_scale_type comb_scale
);
  import cstc_pkg::*;

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [1:0] pin_ev_r;
  logic [15:0] start_hold_r, freq_hold_r, freq_lo_r, freq_hi_r;
  logic [15:0] phase_r;
  logic [8:0] ctrl_r;
  logic [11:0] decim_r, scale_r;
  logic [8:0] interp_r;
  logic [15:0] start_cnt_r, hop_cnt_r;
  logic start_run_r, hop_run_r;
  logic asleep_r, ack_r, qual_d_r, align_d_r;
  logic [31:0] freq_act_r;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire [7:0] idx = avs_address[ADDR_W-1:2];
  wire req = (avs_read | avs_write) & ~ack_r;
  // writes land on the edge where waitrequest is seen low
  wire wr = avs_write & ack_r;
  wire wr_lo = wr & avs_byteenable[0];
  wire wr_hi = wr & avs_byteenable[1];

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic lo, input logic hi);
    merge16 = {hi ? d[15:8] : old[15:8], lo ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  wire wr_any = wr_lo | wr_hi;
  wire [15:0] wd16 = avs_writedata[15:0];

  // ----------------------------------------------------------------
  // sample qualification
  // ----------------------------------------------------------------
  wire cstc_mode_type mode = cstc_mode_type'(ctrl_r[C_MODE_LO+:2]);
  wire cstc_port_type sel_port = ctrl_r[C_PORTB] ? port_b : port_a; // R12
  wire qual = sel_port.qualifier;
  logic accept;
  always_comb begin
    case (mode)
      MODE_EVERY: accept = 1'b1; // R13
      MODE_QUAL: accept = qual; // R14
      MODE_RISE: accept = qual & ~qual_d_r; // R15
      MODE_FALL: accept = ~qual & qual_d_r; // R16
      default: accept = 1'b0;
    endcase
  end
  wire mask_zero = (mode == MODE_EVERY) & ~qual; // R13
  wire cstc_sample_type i_in = mask_zero ? '0 :
    ctrl_r[C_BYPASS] ? {port_a.mantissa, port_a.exponent} :
    {sel_port.mantissa, sel_port.exponent}; // R18
  wire cstc_sample_type q_in = ctrl_r[C_BYPASS] & ~mask_zero ?
    {port_b.mantissa, port_b.exponent} : '0; // R18

  // ----------------------------------------------------------------
  // sync events
  // ----------------------------------------------------------------
  wire align_now = align_pins[ctrl_r[C_ALIGN_LO+:2]]; // R11
  wire pin_pulse = align_now & ~align_d_r;
  wire soft_wr = wr_lo & hit(idx, IDX_SOFT_EVENT);
  wire start_ev = (soft_wr & avs_writedata[EV_START]) |
    (pin_pulse & pin_ev_r[EV_START]); // R1 R23
  wire hop_ev = (soft_wr & avs_writedata[EV_HOP]) |
    (pin_pulse & pin_ev_r[EV_HOP]); // R1 R23
  // value zero suppresses, one fires at once
  wire start_now = start_ev & (start_hold_r == HOLD_ONE); // R4
  wire start_arm = start_ev & (start_hold_r > HOLD_ONE); // R4
  wire start_done = start_now |
    (start_run_r & accept & (start_cnt_r == HOLD_TWO)); // R2 R25
  wire hop_now = hop_ev & (freq_hold_r == HOLD_ONE); // R6
  wire hop_arm = hop_ev & (freq_hold_r > HOLD_ONE); // R6
  wire hop_done = hop_now |
    (hop_run_r & accept & (hop_cnt_r == HOLD_TWO)); // R5 R25
  wire shadow_wr = wr_any & (hit(idx, IDX_FREQ_LO) | hit(idx, IDX_FREQ_HI));
  wire [15:0] lo_nxt = (wr_any & hit(idx, IDX_FREQ_LO)) ?
    merge16(freq_lo_r, avs_writedata, wr_lo, wr_hi) : freq_lo_r;
  wire [15:0] hi_nxt = (wr_any & hit(idx, IDX_FREQ_HI)) ?
    merge16(freq_hi_r, avs_writedata, wr_lo, wr_hi) : freq_hi_r;
  wire wake = start_done & asleep_r; // R2
  wire load_freq = hop_done | wake |
    (shadow_wr & (freq_hold_r == HOLD_ONE)); // R8 R9

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  logic [31:0] rdata;
  always_comb begin
    rdata = '0;
    case (idx)
      IDX_PIN_EVENT: rdata[1:0] = pin_ev_r;
      IDX_START_HOLD: rdata[15:0] = start_hold_r;
      IDX_FREQ_HOLD: rdata[15:0] = freq_hold_r;
      IDX_FREQ_LO: rdata[15:0] = freq_lo_r;
      IDX_FREQ_HI: rdata[15:0] = freq_hi_r;
      IDX_PHASE: rdata[15:0] = phase_r;
      IDX_CTRL: rdata[8:0] = ctrl_r;
      IDX_DECIM: rdata[11:0] = decim_r;
      IDX_INTERP: rdata[8:0] = interp_r;
      IDX_SCALE: rdata[11:0] = scale_r;
      IDX_STATUS: rdata[2:0] = {hop_run_r, start_run_r, asleep_r};
      default: rdata = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pin_ev_r <= '0;
      start_hold_r <= HOLD_ZERO;
      freq_hold_r <= HOLD_ZERO;
      freq_lo_r <= '0;
      freq_hi_r <= '0;
      phase_r <= '0;
      ctrl_r <= CTRL_RST;
      decim_r <= DECIM_RST;
      interp_r <= INTERP_RST;
      scale_r <= '0;
    end else begin
      freq_lo_r <= lo_nxt;
      freq_hi_r <= hi_nxt;
      if (wr_lo & hit(idx, IDX_PIN_EVENT)) pin_ev_r <= wd16[1:0]; // R1
      if (wr_any & hit(idx, IDX_START_HOLD))
        start_hold_r <= merge16(start_hold_r, avs_writedata, wr_lo, wr_hi);
      if (wr_any & hit(idx, IDX_FREQ_HOLD))
        freq_hold_r <= merge16(freq_hold_r, avs_writedata, wr_lo, wr_hi);
      if (wr_any & hit(idx, IDX_PHASE))
        phase_r <= merge16(phase_r, avs_writedata, wr_lo, wr_hi); // R10
      if (wr_any & hit(idx, IDX_CTRL)) begin
        ctrl_r <= {wr_hi ? wd16[8] : ctrl_r[8],
                   wr_lo ? wd16[7:0] : ctrl_r[7:0]};
      end
      if (wr_any & hit(idx, IDX_DECIM)) begin
        decim_r <= {wr_hi ? wd16[11:8] : decim_r[11:8],
                    wr_lo ? wd16[7:0] : decim_r[7:0]}; // R19
      end
      if (wr_any & hit(idx, IDX_INTERP)) begin
        interp_r <= {wr_hi ? wd16[8] : interp_r[8],
                     wr_lo ? wd16[7:0] : interp_r[7:0]}; // R20
      end
      if (wr_any & hit(idx, IDX_SCALE)) begin
        scale_r <= {wr_hi ? wd16[11:8] : scale_r[11:8],
                    wr_lo ? wd16[7:0] : scale_r[7:0]}; // R21
      end
    end
  end

  // ----------------------------------------------------------------
  // hold-off counters, independent
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      start_cnt_r <= HOLD_ZERO;
      start_run_r <= 1'b0;
      hop_cnt_r <= HOLD_ZERO;
      hop_run_r <= 1'b0;
    end else begin
      if (start_arm) begin // R2 R24
        start_cnt_r <= start_hold_r;
        start_run_r <= 1'b1;
      end else if (start_run_r & accept) begin // R25
        start_cnt_r <= start_cnt_r - HOLD_ONE;
        if (start_done) start_run_r <= 1'b0;
      end
      if (hop_arm) begin // R5 R24
        hop_cnt_r <= freq_hold_r;
        hop_run_r <= 1'b1;
      end else if (hop_run_r & accept) begin // R25
        hop_cnt_r <= hop_cnt_r - HOLD_ONE;
        if (hop_done) hop_run_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // channel state and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      asleep_r <= 1'b1;
      ack_r <= 1'b0;
      qual_d_r <= 1'b0;
      align_d_r <= 1'b0;
      freq_act_r <= '0;
      filter_realign <= 1'b0;
      tuning_oscillator_acc_clear <= 1'b0;
      channel_sample_valid <= 1'b0;
      channel_sample <= '0;
      quadrature_sample <= '0;
      avs_readdata <= '0;
    end else begin
      ack_r <= req;
      qual_d_r <= qual;
      align_d_r <= align_now;
      if (wake) asleep_r <= 1'b0; // R2
      filter_realign <= start_done & ~asleep_r; // R3
      if (load_freq) freq_act_r <= {hi_nxt, lo_nxt}; // R5 R8 R9
      tuning_oscillator_acc_clear <= hop_done & ctrl_r[C_CLRACC]; // R7
      channel_sample_valid <= accept & ~asleep_r;
      if (accept) begin
        channel_sample <= i_in;
        quadrature_sample <= q_in;
      end
      if (req & avs_read) avs_readdata <= rdata;
    end
  end

  // one wait state: answer on the edge after the request is seen
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign channel_asleep = asleep_r;
  assign tuning_oscillator_freq = freq_act_r;
  assign tuning_oscillator_phase_offset = phase_r; // R10
  assign tuning_oscillator_dither = ctrl_r[C_DITH_LO+:2]; // R17
  assign tuning_oscillator_bypass = ctrl_r[C_BYPASS]; // R18
  assign comb_decimation_factor = decim_r; // R19
  assign comb_interpolation_factor = interp_r; // R20
  assign comb_scale.scale = level_indicator_pin ?
    scale_r[S_HIGH_LO+:5] : scale_r[S_LOW_LO+:5]; // R22
  assign comb_scale.exp_invert = scale_r[S_POL]; // R21
  assign comb_scale.exp_12db = scale_r[S_WEIGHT]; // R21
endmodule

/* rtl/cstc_pkg.sv */
// package for channel sync and tuning control: map, fields, carriers
// assumes a 32-bit avalon-mm slave with byte addresses, map shown as word indexes
package cstc_pkg;
  localparam int ADDR_W = 10;
  // printed offsets are indexes; byte address is four times the index
  localparam logic [7:0] IDX_SOFT_EVENT = 8'h81;
  localparam logic [7:0] IDX_PIN_EVENT = 8'h82;
  localparam logic [7:0] IDX_START_HOLD = 8'h83;
  localparam logic [7:0] IDX_FREQ_HOLD = 8'h84;
  localparam logic [7:0] IDX_FREQ_LO = 8'h85;
  localparam logic [7:0] IDX_FREQ_HI = 8'h86;
  localparam logic [7:0] IDX_PHASE = 8'h87;
  localparam logic [7:0] IDX_CTRL = 8'h88;
  localparam logic [7:0] IDX_DECIM = 8'h90;
  localparam logic [7:0] IDX_INTERP = 8'h91;
  localparam logic [7:0] IDX_SCALE = 8'h92;
  localparam logic [7:0] IDX_RSVD = 8'h93;
  localparam logic [7:0] IDX_STATUS = 8'h98;
  // event bit positions (soft and pin event registers)
  localparam int EV_START = 0;
  localparam int EV_HOP = 1;
  // control field positions
  localparam int C_BYPASS = 0;
  localparam int C_DITH_LO = 1;
  localparam int C_CLRACC = 3;
  localparam int C_MODE_LO = 4;
  localparam int C_PORTB = 6;
  localparam int C_ALIGN_LO = 7;
  // scale field positions
  localparam int S_LOW_LO = 0;
  localparam int S_HIGH_LO = 5;
  localparam int S_WEIGHT = 10;
  localparam int S_POL = 11;
  localparam logic [15:0] HOLD_ONE = 16'h0001;
  localparam logic [15:0] HOLD_ZERO = 16'h0000;
  localparam logic [15:0] HOLD_TWO = 16'h0002;
  localparam logic [8:0] CTRL_RST = 9'h000;
  localparam logic [11:0] DECIM_RST = 12'h001;
  localparam logic [8:0] INTERP_RST = 9'h000;

  typedef enum logic [1:0] {
    MODE_EVERY, MODE_QUAL, MODE_RISE, MODE_FALL
  } cstc_mode_type;

  typedef struct packed {
    logic [13:0] mantissa;
    logic [2:0] exponent;
    logic qualifier;
  } cstc_port_type;

  typedef struct packed {
    logic [13:0] mantissa;
    logic [2:0] exponent;
  } cstc_sample_type;

  typedef struct packed {
    logic [4:0] scale;
    logic exp_invert;
    logic exp_12db;
  } cstc_scale_type;
endpackage

/* tb/cstc_props.sv */
// checker for cstc_top: bus answer, sleep, sample path, control outputs
// assumes it is bound to cstc_top and sees only its ports
`timescale 1ns/1ps
module cstc_props
  import cstc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [cstc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  input wire cstc_pkg::cstc_port_type port_a,
  input wire cstc_pkg::cstc_port_type port_b,
  input wire logic level_indicator_pin,
  input wire logic channel_asleep,
  input wire logic channel_sample_valid,
  input wire cstc_pkg::cstc_sample_type channel_sample,
  input wire cstc_pkg::cstc_sample_type quadrature_sample,
  input wire logic filter_realign,
  input wire logic tuning_oscillator_acc_clear,
  input wire logic [1:0] tuning_oscillator_dither,
  input wire logic tuning_oscillator_bypass,
  input wire cstc_pkg::cstc_scale_type comb_scale
);
  // ------------------------------------------------------------
  // shadows of control and scale, taken at the write edge
  // ------------------------------------------------------------
  logic [8:0] ctrl_r;
  logic [11:0] scale_r;
  cstc_port_type sel;
  cstc_sample_type sel_d;
  cstc_sample_type b_d;
  wire wr_take = avs_write && !avs_waitrequest;
  wire q_sel = ctrl_r[C_PORTB] ? port_b.qualifier : port_a.qualifier;
  assign sel = (ctrl_r[C_PORTB] && !ctrl_r[C_BYPASS]) ? port_b : port_a;
  assign sel_d = {sel.mantissa, sel.exponent};
  assign b_d = {port_b.mantissa, port_b.exponent};
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ctrl_r <= CTRL_RST;
      scale_r <= 12'h000;
    end else if (wr_take && avs_address[9:2] == IDX_CTRL) begin
      ctrl_r <= avs_writedata[8:0];
    end else if (wr_take && avs_address[9:2] == IDX_SCALE) begin
      scale_r <= avs_writedata[11:0];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence s_taken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  property p_answer;
    s_taken |=> !avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer after wait");
  property p_stay_awake;
    !channel_asleep |=> !channel_asleep;
  endproperty
  a_stay_awake: assert property (p_stay_awake) else $error("slept again");
  property p_realign;
    filter_realign |-> !$past(channel_asleep);
  endproperty
  a_realign: assert property (p_realign) else $error("realign asleep");
  property p_mask;
    channel_sample_valid && $past(ctrl_r[5:4] == 2'b00) |->
      channel_sample == ($past(q_sel) ? $past(sel_d) : '0);
  endproperty
  a_mask: assert property (p_mask) else $error("mode 00 data");
  property p_qual;
    channel_sample_valid && $past(ctrl_r[5:4] == 2'b01) |->
      $past(q_sel) && channel_sample == $past(sel_d);
  endproperty
  a_qual: assert property (p_qual) else $error("mode 01 data");
  property p_edge;
    channel_sample_valid && $past(ctrl_r[5]) |->
      channel_sample == $past(sel_d);
  endproperty
  a_edge: assert property (p_edge) else $error("edge mode data");
  property p_quad;
    channel_sample_valid && $past(ctrl_r[5:4] == 2'b01 || !ctrl_r[0]) |->
      quadrature_sample == ($past(ctrl_r[0]) ? $past(b_d) : '0);
  endproperty
  a_quad: assert property (p_quad) else $error("q path data");
  property p_bypass;
    tuning_oscillator_bypass == ctrl_r[C_BYPASS];
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass out");
  property p_dither;
    tuning_oscillator_dither == ctrl_r[2:1];
  endproperty
  a_dither: assert property (p_dither) else $error("dither out");
  property p_scale_bits;
    comb_scale.exp_invert == scale_r[S_POL] &&
      comb_scale.exp_12db == scale_r[S_WEIGHT];
  endproperty
  a_scale_bits: assert property (p_scale_bits) else $error("scale bits");
  property p_scale_sel;
    comb_scale.scale == (level_indicator_pin ? scale_r[9:5] : scale_r[4:0]);
  endproperty
  a_scale_sel: assert property (p_scale_sel) else $error("scale sel");
  property p_acc_clear;
    tuning_oscillator_acc_clear |-> $past(ctrl_r[3]) ##1
      !tuning_oscillator_acc_clear;
  endproperty
  a_acc_clear: assert property (p_acc_clear) else $error("acc clear");
endmodule
bind cstc_top cstc_props i_cstc_props (.clk_sys, .rstn, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_waitrequest, .port_a,
  .port_b, .level_indicator_pin, .channel_asleep, .channel_sample_valid,
  .channel_sample, .quadrature_sample, .filter_realign,
  .tuning_oscillator_acc_clear, .tuning_oscillator_dither,
  .tuning_oscillator_bypass, .comb_scale);

/* tb/cstc_adc_model.sv */
// converter stand-in: two sample ports, qualifiers random
// assumes clk_sys from the bench; the pattern shifts one bit each cycle
`timescale 1ns/1ps
module cstc_adc_model
  import cstc_pkg::*;
(
  input wire logic clk_sys,
  output cstc_pkg::cstc_port_type port_a,
  output cstc_pkg::cstc_port_type port_b
);
  logic [35:0] lfsr_r = 36'h000000016;
  initial port_a = '0;
  initial port_b = '0;
  always @(posedge clk_sys) begin
    lfsr_r <= {lfsr_r[34:0], lfsr_r[35] ^ lfsr_r[24]};
    port_a <= lfsr_r[17:0];
    port_b <= lfsr_r[35:18];
  end
endmodule

/* tb/cstc_top_test.sv */
// bench for cstc_top: registers, events, hops, sample-rate modes
// assumes cstc_adc_model drives both ports; checker bound separately
`timescale 1ns/1ps
module cstc_top_test;
  import cstc_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata, tuning_oscillator_freq, q, seed = 32'h00000016;
  logic avs_waitrequest, channel_asleep, channel_sample_valid;
  logic filter_realign, tuning_oscillator_acc_clear, tuning_oscillator_bypass;
  logic qn, q_prev;
  cstc_port_type port_a, port_b;
  logic [3:0] align_pins = '0;
  logic level_indicator_pin = 1'b0;
  cstc_sample_type channel_sample, quadrature_sample;
  cstc_scale_type comb_scale;
  logic [15:0] tuning_oscillator_phase_offset, cur_ctrl = '0, wv [11];
  logic [1:0] tuning_oscillator_dither;
  logic [11:0] comb_decimation_factor;
  logic [8:0] comb_interpolation_factor;
  int num_errors = 0, num_checks = 0, cyc = 0, n, n_exp, n_act, n_rel, n_clr;
  localparam logic [7:0] REGS [11] = '{IDX_PIN_EVENT, IDX_START_HOLD,
    IDX_FREQ_HOLD, IDX_FREQ_LO, IDX_FREQ_HI, IDX_PHASE, IDX_CTRL, IDX_DECIM,
    IDX_INTERP, IDX_SCALE, IDX_RSVD};
  always #12.5 clk_sys = ~clk_sys;
  cstc_adc_model i_cstc_adc_model (.clk_sys, .port_a, .port_b);
  cstc_top i_cstc_top (.clk_sys, .rstn, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest,
    .port_a, .port_b, .align_pins, .level_indicator_pin, .channel_asleep,
    .channel_sample_valid, .channel_sample, .quadrature_sample,
    .filter_realign, .tuning_oscillator_freq, .tuning_oscillator_phase_offset,
    .tuning_oscillator_acc_clear, .tuning_oscillator_dither,
    .tuning_oscillator_bypass, .comb_decimation_factor,
    .comb_interpolation_factor, .comb_scale);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [15:0] wmask(input logic [7:0] i);
    case (i)
      IDX_CTRL, IDX_INTERP: wmask = 16'h01ff;
      IDX_DECIM, IDX_SCALE: wmask = 16'h0fff;
      IDX_RSVD: wmask = 16'h0000;
      IDX_PIN_EVENT: wmask = 16'h0003;
      default: wmask = 16'hffff;
    endcase
  endfunction
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] a, input logic [31:0] e);
    num_checks++;
    if (a !== e) begin
      num_errors++;
      $display("BAD t=%0t act=%h exp=%h", $time, a, e);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] i, input logic [15:0] d,
                     output logic [31:0] r);
    avs_address <= {i, 2'b00};
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {16'h0000, d};
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rdc(input logic [7:0] i, input logic [31:0] e);
    acc(1'b0, i, 16'h0000, q);
    chk(q, e);
  endtask
  task automatic pulse(input int k);
    align_pins[k] <= 1'b1;
    @(posedge clk_sys);
    align_pins[k] <= 1'b0;
    @(posedge clk_sys);
  endtask
  // ------------------------------------------------------------
  // monitor: expected accepts per mode, pulse counts, timeout
  // ------------------------------------------------------------
  always @(posedge clk_sys) begin
    qn = cur_ctrl[6] ? port_b.qualifier : port_a.qualifier;
    case (cur_ctrl[5:4])
      2'b00: n_exp += 1;
      2'b01: n_exp += qn;
      2'b10: n_exp += qn && !q_prev;
      default: n_exp += !qn && q_prev;
    endcase
    q_prev = qn;
    n_act += channel_sample_valid;
    n_rel += filter_realign;
    n_clr += tuning_oscillator_acc_clear;
    level_indicator_pin <= port_a.mantissa[3];
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      stop_test();
    end
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    foreach (REGS[k]) rdc(REGS[k], {31'h0, REGS[k] == IDX_DECIM});
    rdc(8'h00, 32'h00000000);
    chk(32'(channel_asleep), 32'h1);
    foreach (REGS[k]) begin
      wv[k] = 16'(xs());
      if (REGS[k] == IDX_DECIM) wv[k][11] = 1'b1;
      if (REGS[k] == IDX_INTERP) wv[k][8] = 1'b0;
      if (REGS[k] == IDX_RSVD) wv[k] = 16'h0000;
      acc(1'b1, REGS[k], wv[k], q);
      rdc(REGS[k], {16'h0000, wv[k] & wmask(REGS[k])});
    end
    chk(32'(tuning_oscillator_phase_offset), 32'(wv[5]));
    chk(32'(comb_decimation_factor), 32'(wv[7][11:0]));
    chk(32'(comb_interpolation_factor), 32'(wv[8][8:0]));
    cur_ctrl = 16'h0008;
    acc(1'b1, IDX_CTRL, cur_ctrl, q);
    acc(1'b1, IDX_START_HOLD, 16'h0000, q);
    acc(1'b1, IDX_FREQ_HOLD, 16'h0001, q);
    acc(1'b1, IDX_FREQ_LO, 16'h1234, q);
    acc(1'b1, IDX_FREQ_HI, 16'h5678, q);
    chk(tuning_oscillator_freq, 32'h56781234);
    acc(1'b1, IDX_FREQ_HOLD, 16'h0000, q);
    acc(1'b1, IDX_FREQ_LO, 16'haaaa, q);
    acc(1'b1, IDX_FREQ_HI, 16'hbbbb, q);
    acc(1'b1, IDX_SOFT_EVENT, 16'h0003, q);
    repeat (8) @(posedge clk_sys);
    chk(tuning_oscillator_freq, 32'h56781234);
    chk(32'(channel_asleep), 32'h1);
    acc(1'b1, IDX_FREQ_HOLD, 16'h0014, q);
    n_clr = 0;
    acc(1'b1, IDX_SOFT_EVENT, 16'h0002, q);
    for (n = 0; tuning_oscillator_freq !== 32'hbbbbaaaa && n < 60; n++)
      @(posedge clk_sys);
    chk(tuning_oscillator_freq, 32'hbbbbaaaa);
    chk(32'(n inside {[15:20]}), 32'h1);
    @(posedge clk_sys);
    chk(32'(n_clr), 32'h1);
    acc(1'b1, IDX_FREQ_LO, 16'hcccc, q);
    acc(1'b1, IDX_FREQ_HI, 16'hdddd, q);
    acc(1'b1, IDX_PIN_EVENT, 16'h0001, q);
    acc(1'b1, IDX_START_HOLD, 16'h0006, q);
    cur_ctrl = 16'h0100;
    acc(1'b1, IDX_CTRL, cur_ctrl, q);
    pulse(1);
    repeat (12) @(posedge clk_sys);
    chk(32'(channel_asleep), 32'h1);
    pulse(2);
    for (n = 0; channel_asleep !== 1'b0 && n < 30; n++) @(posedge clk_sys);
    chk(32'(channel_asleep), 32'h0);
    chk(32'(n inside {[1:10]}), 32'h1);
    chk(tuning_oscillator_freq, 32'hddddcccc);
    acc(1'b1, IDX_FREQ_LO, 16'heeee, q);
    acc(1'b1, IDX_FREQ_HI, 16'hffff, q);
    acc(1'b1, IDX_FREQ_HOLD, 16'h000c, q);
    n_rel = 0;
    acc(1'b1, IDX_SOFT_EVENT, 16'h0003, q);
    repeat (7) @(posedge clk_sys);
    chk(32'(n_rel), 32'h1);
    chk(tuning_oscillator_freq, 32'hddddcccc);
    repeat (12) @(posedge clk_sys);
    chk(tuning_oscillator_freq, 32'hffffeeee);
    for (int m = 0; m < 4; m++) begin
      cur_ctrl = {9'h000, m == 3, 2'(m), 3'h0, m == 1};
      acc(1'b1, IDX_CTRL, cur_ctrl, q);
      n_exp = 0;
      n_act = 0;
      repeat (64) @(posedge clk_sys);
      chk(32'((n_exp - n_act) inside {[-3:3]}), 32'h1);
    end
    stop_test();
  end
endmodule
